/* File: msr_cfg.svh */
// constants for the mixed-signal status register block
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH
`define MSR_NPORTS          12
`define MSR_ADDR_W          4
// register indices on the register port; four bits, the event halves sit above 7
`define MSR_IDX_INTSUM      4'h0
`define MSR_IDX_NEW_A       4'h1
`define MSR_IDX_NEW_B       4'h2
`define MSR_IDX_OVC_A       4'h3
`define MSR_IDX_OVC_B       4'h4
`define MSR_IDX_TMP_INT     4'h5
`define MSR_IDX_TMP_REM1    4'h6
`define MSR_IDX_TMP_REM2    4'h7
`define MSR_IDX_EVT_A       4'h8
`define MSR_IDX_EVT_B       4'h9
// field positions of the split port flags
`define MSR_LO_PORTS        6
`define MSR_LO_POS          2
`define MSR_HI_POS          11
`define MSR_TMP_W           12
`define MSR_RESET_VAL       16'h0000
// edge selector codes
`define MSR_EDGE_NONE       2'b00
`define MSR_EDGE_RISE       2'b01
`define MSR_EDGE_FALL       2'b10
`define MSR_EDGE_BOTH       2'b11
`endif

/* File: msr_dev.sv */
// device end: status flags, temperatures and register read port
// Notes on behaviour
// - fresh converter result sets port new-data flag
// - averaged port flags only after full set
// - ports 0-5 bits 7:2, 6-10 15:11, 11 bit0
// - new-data flags ignore interrupt masks
// - clear after summary read then both reads
// - driver overcurrent sets port flag, same layout
// - host reads both overcurrent registers after interrupt
// - overcurrent flags ignore interrupt masks
// - overcurrent clear after summary then both reads
// - internal temperature 12-bit two's complement, eighth degree
// - remote one temperature 12-bit two's complement
// - remote two temperature 12-bit two's complement
// - selected input edge sets port event flag
// - host reads both event registers after interrupt
// - input-event flags ignore interrupt masks
// - event clear after summary then both reads
// - edge select 00 none 01 rise 10 fall 11 both
// - overwriting unread result raises missed-data interrupt
`timescale 1ns/1ps
`include "msr_cfg.svh"
module msr_dev
  import msr_pkg::*;
#(
  parameter int NPORTS = `MSR_NPORTS,
  parameter int AVG_LOG2 = 0
) (
  // clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   nrst_in,
  // register port
  msr_if.dev                          bus,
  // converter side
  input  wire logic [NPORTS-1:0]      conv_sample_in,
  input  wire logic [NPORTS-1:0]      avg_enable_in,
  // driver and input sides
  input  wire logic [NPORTS-1:0]      drv_overcurrent_in,
  input  wire logic [NPORTS-1:0]      gpi_level_in,
  input  wire logic [2*NPORTS-1:0]    input_edge_select_in,
  // temperatures
  input  wire logic [`MSR_TMP_W-1:0]  temp_int_in,
  input  wire logic [`MSR_TMP_W-1:0]  temp_rem1_in,
  input  wire logic [`MSR_TMP_W-1:0]  temp_rem2_in,
  input  wire logic                   temp_valid_in,
  // summary events
  output logic                        conv_data_missed_interrupt_out,
  output logic                        input_event_interrupt_out,
  output logic                        overcurrent_interrupt_out
);
  logic [NPORTS-1:0]     result_wr;
  logic [NPORTS-1:0]     edge_hit;
  logic [NPORTS-1:0]     gpi_prev_r;
  logic [NPORTS-1:0]     ovc_prev_r;
  logic [NPORTS-1:0]     new_flags;
  logic [NPORTS-1:0]     ovc_flags;
  logic [NPORTS-1:0]     evt_flags;
  logic [`MSR_TMP_W-1:0] t_int_r;
  logic [`MSR_TMP_W-1:0] t_rem1_r;
  logic [`MSR_TMP_W-1:0] t_rem2_r;
  logic                  rd_take;
  logic                  rd_sum;
  logic                  rd_new_a;
  logic                  rd_new_b;
  logic                  rd_ovc_a;
  logic                  rd_ovc_b;
  logic                  rd_evt_a;
  logic                  rd_evt_b;
  logic [15:0]           rd_nxt;

  // per-port averaging counter and edge detector
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      logic [7:0] avg_cnt_r;
      logic       avg_done;
      assign avg_done = !avg_enable_in[g] ||
                        (avg_cnt_r == 8'((1 << AVG_LOG2) - 1));
      // result written only once the averaging set is complete
      always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
          avg_cnt_r <= 8'h00;
        end else if (conv_sample_in[g]) begin
          avg_cnt_r <= avg_done ? 8'h00 : avg_cnt_r + 8'h01;
        end
      end
      assign result_wr[g] = conv_sample_in[g] && avg_done;
      // edge selection per port
      always_comb begin
        case (input_edge_select_in[2*g +: 2])
          `MSR_EDGE_RISE: edge_hit[g] = gpi_level_in[g] && !gpi_prev_r[g];
          `MSR_EDGE_FALL: edge_hit[g] = !gpi_level_in[g] && gpi_prev_r[g];
          `MSR_EDGE_BOTH: edge_hit[g] = gpi_level_in[g] ^ gpi_prev_r[g];
          default:        edge_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // previous levels for edge and overcurrent onset detection
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      // seeded from the pins so a level already high gives no false edge after reset
      gpi_prev_r <= gpi_level_in;
      ovc_prev_r <= drv_overcurrent_in;
    end else begin
      gpi_prev_r <= gpi_level_in;
      ovc_prev_r <= drv_overcurrent_in;
    end
  end

  // read decode of the host port
  assign rd_take  = bus.rd_req && !bus.rd_ack;
  assign rd_sum   = rd_take && (bus.rd_addr == `MSR_IDX_INTSUM);
  assign rd_new_a = rd_take && (bus.rd_addr == `MSR_IDX_NEW_A);
  assign rd_new_b = rd_take && (bus.rd_addr == `MSR_IDX_NEW_B);
  assign rd_ovc_a = rd_take && (bus.rd_addr == `MSR_IDX_OVC_A);
  assign rd_ovc_b = rd_take && (bus.rd_addr == `MSR_IDX_OVC_B);
  assign rd_evt_a = rd_take && (bus.rd_addr == `MSR_IDX_EVT_A);
  assign rd_evt_b = rd_take && (bus.rd_addr == `MSR_IDX_EVT_B);

  // three flag groups share one clearing scheme
  msr_flag_group #(.NPORTS(NPORTS)) u_new (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .set_in      (result_wr),
    .sum_rd_in   (rd_sum),
    .a_rd_in     (rd_new_a),
    .b_rd_in     (rd_new_b),
    .flags_out   (new_flags)
  );
  msr_flag_group #(.NPORTS(NPORTS)) u_ovc (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .set_in      (drv_overcurrent_in & ~ovc_prev_r),
    .sum_rd_in   (rd_sum),
    .a_rd_in     (rd_ovc_a),
    .b_rd_in     (rd_ovc_b),
    .flags_out   (ovc_flags)
  );
  msr_flag_group #(.NPORTS(NPORTS)) u_evt (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .set_in      (edge_hit),
    .sum_rd_in   (rd_sum),
    .a_rd_in     (rd_evt_a),
    .b_rd_in     (rd_evt_b),
    .flags_out   (evt_flags)
  );

  // temperature capture on each new measurement
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      t_int_r  <= '0;
      t_rem1_r <= '0;
      t_rem2_r <= '0;
    end else if (temp_valid_in) begin
      t_int_r  <= temp_int_in;
      t_rem1_r <= temp_rem1_in;
      t_rem2_r <= temp_rem2_in;
    end
  end

  // summary events; overwrite of an unread result counts as missed
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      conv_data_missed_interrupt_out <= 1'b0;
      input_event_interrupt_out      <= 1'b0;
      overcurrent_interrupt_out      <= 1'b0;
    end else begin
      conv_data_missed_interrupt_out <= (|(result_wr & new_flags)) ||
                                        (conv_data_missed_interrupt_out && !rd_sum);
      input_event_interrupt_out      <= |evt_flags;
      overcurrent_interrupt_out      <= |ovc_flags;
    end
  end

  // read mux; port 11 on bit 0 of the second register
  always_comb begin
    rd_nxt = `MSR_RESET_VAL;
    case (bus.rd_addr)
      `MSR_IDX_INTSUM: begin
        rd_nxt = {10'h000, overcurrent_interrupt_out, 1'b0, input_event_interrupt_out,
                  conv_data_missed_interrupt_out, |new_flags, 1'b0};
      end
      `MSR_IDX_NEW_A: begin
        rd_nxt = {new_flags[10:6], 3'h0, new_flags[5:0], 2'h0};
      end
      `MSR_IDX_NEW_B:    rd_nxt = {15'h0000, new_flags[11]};
      `MSR_IDX_OVC_A:    rd_nxt = {ovc_flags[10:6], 3'h0, ovc_flags[5:0], 2'h0};
      `MSR_IDX_OVC_B:    rd_nxt = {15'h0000, ovc_flags[11]};
      `MSR_IDX_TMP_INT:  rd_nxt = {4'h0, t_int_r};
      `MSR_IDX_TMP_REM1: rd_nxt = {4'h0, t_rem1_r};
      `MSR_IDX_TMP_REM2: rd_nxt = {4'h0, t_rem2_r};
      `MSR_IDX_EVT_A:    rd_nxt = {evt_flags[10:6], 3'h0, evt_flags[5:0], 2'h0};
      `MSR_IDX_EVT_B:    rd_nxt = {15'h0000, evt_flags[11]};
      default: rd_nxt = `MSR_RESET_VAL;
    endcase
  end

  // one-cycle acknowledge with registered data
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      bus.rd_ack  <= 1'b0;
      bus.rd_data <= `MSR_RESET_VAL;
    end else begin
      bus.rd_ack <= rd_take;
      if (rd_take) begin
        bus.rd_data <= rd_nxt;
      end
    end
  end
endmodule

/* File: msr_flag_group.sv */
// one set of twelve sticky port flags with read-sequence clearing
`timescale 1ns/1ps
`include "msr_cfg.svh"
module msr_flag_group
  import msr_pkg::*;
#(
  parameter int NPORTS = `MSR_NPORTS
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              nrst_in,
  // per-port set strobes
  input  wire logic [NPORTS-1:0] set_in,
  // read events
  input  wire logic              sum_rd_in,
  input  wire logic              a_rd_in,
  input  wire logic              b_rd_in,
  // flag state
  output logic [NPORTS-1:0]      flags_out
);
  msr_clr_t                clr_st_r;
  logic                    a_seen_r;
  logic                    b_seen_r;
  logic                    clr_now;
  // both halves read after the summary read completes the sequence
  assign clr_now = (clr_st_r == MSR_CLR_ARMED) &&
                   ((a_seen_r || a_rd_in) && (b_seen_r || b_rd_in));
  // sequence tracker; a new summary read restarts it
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      clr_st_r <= MSR_CLR_IDLE;
      a_seen_r <= 1'b0;
      b_seen_r <= 1'b0;
    end else if (sum_rd_in) begin
      clr_st_r <= MSR_CLR_ARMED;
      a_seen_r <= 1'b0;
      b_seen_r <= 1'b0;
    end else begin
      case (clr_st_r)
        MSR_CLR_ARMED: begin
          if (clr_now) begin
            clr_st_r <= MSR_CLR_IDLE;
            a_seen_r <= 1'b0;
            b_seen_r <= 1'b0;
          end else begin
            a_seen_r <= a_seen_r | a_rd_in;
            b_seen_r <= b_seen_r | b_rd_in;
          end
        end
        default: begin
          clr_st_r <= MSR_CLR_IDLE;
        end
      endcase
    end
  end
  // flags are never gated by masks; a set in the clear cycle wins
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      flags_out <= '0;
    end else if (clr_now && !sum_rd_in) begin
      flags_out <= set_in;
    end else begin
      flags_out <= flags_out | set_in;
    end
  end
endmodule

/* File: msr_host.sv */
// host end: issues register reads; the user orders the clearing sequence
`timescale 1ns/1ps
`include "msr_cfg.svh"
module msr_host
  import msr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // user request
  input  wire logic        req_in,
  input  wire logic [3:0]  addr_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      data_out,
  // register port
  msr_if.host              bus
);
  msr_host_st_t st_r;
  // one read at a time; the user orders summary then both halves
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st_r        <= MSR_H_IDLE;
      bus.rd_req  <= 1'b0;
      bus.rd_addr <= 4'h0;
      busy_out    <= 1'b0;
      done_out    <= 1'b0;
      data_out    <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      case (st_r)
        MSR_H_IDLE: begin
          if (req_in) begin
            bus.rd_req  <= 1'b1;
            bus.rd_addr <= addr_in;
            busy_out    <= 1'b1;
            st_r        <= MSR_H_WAIT;
          end
        end
        MSR_H_WAIT: begin
          if (bus.rd_ack) begin
            bus.rd_req <= 1'b0;
            data_out   <= bus.rd_data;
            done_out   <= 1'b1;
            busy_out   <= 1'b0;
            st_r       <= MSR_H_IDLE;
          end
        end
        default: st_r <= MSR_H_IDLE;
      endcase
    end
  end
endmodule

/* File: msr_if.sv */
// register port between the status device and its host
`timescale 1ns/1ps
interface msr_if;
  logic        rd_req;
  logic [3:0]  rd_addr;
  logic        rd_ack;
  logic [15:0] rd_data;
  modport dev  (input rd_req, input rd_addr, output rd_ack, output rd_data);
  modport host (output rd_req, output rd_addr, input rd_ack, input rd_data);
endinterface

/* File: msr_pkg.sv */
// types shared by both ends of the status register link
package msr_pkg;
  typedef enum logic [1:0] {
    MSR_CLR_IDLE,
    MSR_CLR_ARMED
  } msr_clr_t;
  typedef enum logic [1:0] {
    MSR_H_IDLE,
    MSR_H_REQ,
    MSR_H_WAIT
  } msr_host_st_t;
endpackage

/* File: msr_port_checker.sv */
// handshake and field checks on the status register port
`timescale 1ns/1ps
module msr_port_checker (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // register port
  input  wire logic        rd_req,
  input  wire logic [3:0]  rd_addr,
  input  wire logic        rd_ack,
  input  wire logic [15:0] rd_data
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // handshake: one short answer per request
  property p_ack_pulse;
    rd_ack |=> !rd_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
  property p_ack_cause;
    $rose(rd_ack) |-> $past(rd_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_bound;
    rd_req && !rd_ack |-> ##[1:2] rd_ack;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("request not answered");
  // host holds its request until answered, then lets go
  property p_req_hold;
    rd_req && !rd_ack |=> rd_req && $stable(rd_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop;
    rd_ack |=> !rd_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  // unused bit positions read as zero
  property p_unmapped;
    rd_ack && rd_addr > 4'h9 |-> rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index not zero");
  property p_temp_top;
    rd_ack && rd_addr inside {4'h5, 4'h6, 4'h7} |-> rd_data[15:12] == 4'h0;
  endproperty
  a_temp_top: assert property (p_temp_top) else $error("temperature top bits set");
  property p_half_b;
    rd_ack && rd_addr inside {4'h2, 4'h4, 4'h9} |-> rd_data[15:1] == 15'h0;
  endproperty
  a_half_b: assert property (p_half_b) else $error("second half beyond bit 0");
  property p_half_a;
    rd_ack && rd_addr inside {4'h1, 4'h3, 4'h8} |-> {rd_data[10:8], rd_data[1:0]} == 5'h0;
  endproperty
  a_half_a: assert property (p_half_a) else $error("first half gap bits set");
endmodule

/* File: tb_mixed_signal_status_regs.sv */
// self-checking bench: device and host joined over the register port
`timescale 1ns/1ps
module tb_mixed_signal_status_regs;
  logic        core_clk_in, nrst_in, req_in, busy_out, done_out;
  logic [3:0]  addr_in;
  logic [15:0] data_out;
  logic [11:0] samp, avg_en, ovc, gpi, t_int, t_r1, t_r2;
  logic [23:0] edge_sel;
  logic        t_vld, irq_miss, irq_evt, irq_ovc;
  int          err_total, check_count;
  logic [3:0]  grp [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};

  msr_if bus_if ();
  msr_dev #(.AVG_LOG2(1)) u_msr_dev (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .bus(bus_if), .conv_sample_in(samp), .avg_enable_in(avg_en),
    .drv_overcurrent_in(ovc), .gpi_level_in(gpi), .input_edge_select_in(edge_sel),
    .temp_int_in(t_int), .temp_rem1_in(t_r1), .temp_rem2_in(t_r2), .temp_valid_in(t_vld),
    .conv_data_missed_interrupt_out(irq_miss), .input_event_interrupt_out(irq_evt),
    .overcurrent_interrupt_out(irq_ovc));
  msr_host u_msr_host (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .req_in(req_in),
    .addr_in(addr_in), .busy_out(busy_out), .done_out(done_out), .data_out(data_out),
    .bus(bus_if));
  msr_port_checker u_msr_port_checker (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .rd_req(bus_if.rd_req), .rd_addr(bus_if.rd_addr), .rd_ack(bus_if.rd_ack),
    .rd_data(bus_if.rd_data));

  // free-running 125 MHz clock
  always #4 core_clk_in = ~core_clk_in;

  // expected halves of a port mask
  function automatic logic [15:0] ha(input logic [11:0] m);
    return {m[10:6], 3'h0, m[5:0], 2'h0};
  endfunction
  function automatic logic [15:0] hb(input logic [11:0] m);
    return {15'h0, m[11]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in) #1;
  endtask
  // one read through the host; a spare cycle first lets it settle to idle
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    int n;
    step(1);
    req_in = 1'b1;
    addr_in = a;
    step(1);
    req_in = 1'b0;
    chk({15'h0, busy_out}, 16'h0001);
    for (n = 0; n < 20 && done_out !== 1'b1; n++) step(1);
    if (done_out !== 1'b1) begin
      err_total++;
      end_sim();
    end
    chk(data_out, exp);
    chk({15'h0, busy_out}, 16'h0000);
  endtask
  // halves stay until summary then both halves are read, then clear
  task automatic check_groups(input logic [11:0] mn, input logic [11:0] mo,
                              input logic [11:0] me);
    logic [15:0] vals [6];
    vals = '{ha(mn), hb(mn), ha(mo), hb(mo), ha(me), hb(me)};
    chk({15'h0, irq_evt}, {15'h0, |me});
    chk({15'h0, irq_ovc}, {15'h0, |mo});
    for (int p = 0; p < 3; p++) begin
      if (p == 1) rd(4'h0, {10'h0, |mo, 1'b0, |me, 1'b0, |mn, 1'b0});
      for (int k = 0; k < 6; k++) rd(grp[k], p < 2 ? vals[k] : 16'h0);
    end
  endtask

  // main sequence
  initial begin
    {err_total, check_count} = '0;
    {core_clk_in, nrst_in, req_in, addr_in, samp, avg_en, ovc, gpi, t_vld} = '0;
    t_int = 12'h801;
    t_r1 = 12'hfff;
    t_r2 = 12'h0a5;
    for (int i = 0; i < 12; i++) edge_sel[2*i +: 2] = 2'(i % 4);
    repeat (5) @(posedge core_clk_in);
    #1 nrst_in = 1'b1;
    for (int a = 0; a < 16; a++) if (a < 5 || a > 7) rd(4'(a), 16'h0);
    $display("test reset values done");
    t_vld = 1'b1;
    step(1);
    t_vld = 1'b0;
    rd(4'h5, {4'h0, t_int});
    rd(4'h6, {4'h0, t_r1});
    rd(4'h7, {4'h0, t_r2});
    // without the valid strobe the stored value must hold
    t_int = 12'h7ff;
    rd(4'h5, 16'h0801);
    $display("test temperatures done");
    // rising edges: only codes 01 and 11 flag
    samp = 12'hc21;
    ovc = 12'h842;
    gpi = 12'hfff;
    step(1);
    samp = 12'h0;
    step(3);
    check_groups(12'hc21, 12'h842, 12'haaa);
    $display("test rising round done");
    // falling edges, averaging on port 4 holds its flag back
    avg_en = 12'h010;
    samp = 12'h110;
    ovc = 12'h0;
    gpi = 12'h0;
    step(1);
    samp = 12'h0;
    step(3);
    check_groups(12'h100, 12'h0, 12'hccc);
    samp = 12'h010;
    step(1);
    samp = 12'h0;
    step(3);
    rd(4'h1, 16'h0040);
    $display("test falling and averaging done");
    // overwrite an unread result on port 0
    for (int r = 0; r < 2; r++) begin
      samp = 12'h001;
      step(1);
      samp = 12'h0;
      step(1);
    end
    step(2);
    chk({15'h0, irq_miss}, 16'h1);
    rd(4'h0, 16'h0006);
    step(2);
    chk({15'h0, irq_miss}, 16'h0);
    $display("test missed data done");
    end_sim();
  end
endmodule
